/* rtl/kic_params.svh */
/*
 * Register offsets, field positions, reset values and serial bus constants
 * of the keypad interrupt clear, mask and key code register bank.
 * Assumes inclusion by the bank module only; kic_pkg.sv does not include it.
 */
`ifndef KIC_PARAMS_SVH
`define KIC_PARAMS_SVH

`define KIC_CLEAR_ADDR 8'h08
`define KIC_MASK_ADDR 8'h09
`define KIC_CODE0_ADDR 8'h0B
`define KIC_CODE1_ADDR 8'h0C
`define KIC_CODE3_ADDR 8'h0E

`define KIC_SF_OFF_BIT 7
`define KIC_EVT_CLR_BIT 1
`define KIC_SCAN_CLR_BIT 0

`define KIC_MASK_RESET 4'h3
`define KIC_ROW_RESET 3'h7
`define KIC_COL_RESET 4'hF
`define KIC_KEY_SLOTS 4

// Slave address default is arbitrary and meant to be overridden
`define KIC_BUS_ADDR 7'h2A
`define KIC_BITS_PER_BYTE 4'h8

`endif

/* rtl/kic_pkg.sv */
/*
 * Types shared by the keypad register bank: key code layout, raw interrupt
 * group and serial slave states.
 * Does not include kic_params.svh; field widths are fixed here.
 */
package kic_pkg;

    typedef struct packed {
        logic more;
        logic [2:0] row;
        logic [3:0] col;
    } kic_key_code_t;

    // Bit order matches the mask register: event lost, event, key lost, scan
    typedef struct packed {
        logic event_lost;
        logic event_pend;
        logic key_lost;
        logic scan_change;
    } kic_raw_irq_t;

    typedef enum logic [2:0] {
        KIC_IDLE,
        KIC_RX,
        KIC_ACK,
        KIC_TX,
        KIC_MACK
    } kic_bus_state_t;

endpackage : kic_pkg

/* rtl/kic_bank.sv */
/*
 * Keypad interrupt clear, mask and key code registers behind a serial
 * two-wire slave with auto-incrementing register pointer.
 * Assumes the scan engine and event buffer run on ref_clk_in; the serial
 * pins are asynchronous and are synchronised here.
 */
// How it works
// R1: Clear register is write-only, ones clear interrupts
// R2: Clear bit 7 turns special-key scanning off
// R3: Clear bit 1 flushes buffer, clears event irqs
// R4: Clear bit 0 clears scan and key-lost
// R5: Masked sources never reach the request output; a source masked by a mask write still drives it for one cycle after
// R6: Mask bit 3 gates event-lost, resets 0
// R7: Mask bit 2 gates event, resets 0
// R8: Mask bit 1 gates key-lost, resets 1
// R9: Mask bit 0 gates scan-change, resets 1
// R10: Host masks sources to suit its service style
// R11: Up to four held keys reported
// R12: Bit 7 flags a key in next register
// R13: Reading all four codes clears scan change
// R14: First code reads 0x7F with no key
// R15: Bits 6:4 hold row, reset seven
// R16: Bits 3:0 hold column, reset fifteen
// R17: Two consecutive registers hold keys one, two
// R18: Scan change set when scan state differs
// R19: Key lost on uncleared change or overflow
// R20: Event irq follows buffer not empty
// R21: Event lost set on buffer overflow
// R22: Request asserted while any unmasked irq set
`timescale 1ns/1ns
`default_nettype none
`include "kic_params.svh"

module kic_bank #(
    parameter logic [6:0] BUS_ADDR = `KIC_BUS_ADDR
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic scan_done_in,
    input wire logic scan_changed_in,
    input wire logic too_many_keys_in,
    input wire logic [3:0] key_valid_in,
    input wire kic_pkg::kic_key_code_t [3:0] key_in,
    input wire logic event_pending_in,
    input wire logic event_overflow_in,
    output logic event_buffer_clear_out,
    output logic special_key_scan_off_out,
    output kic_pkg::kic_raw_irq_t raw_irq_out,
    output logic irq_out
);
    import kic_pkg::*;

    // Serial pin synchronisers; first stage feeds only the second
    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
    kic_bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic is_addr, is_ptr, rw;

    logic [3:0] keypad_interrupt_mask;
    kic_raw_irq_t raw;
    kic_key_code_t slot [0:3];
    logic [3:0] read_seen;

    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
    wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;
    wire byte_done = (state == KIC_RX) && scl_fall && (bit_cnt == `KIC_BITS_PER_BYTE);
    wire addr_hit = is_addr && (shift[7:1] == BUS_ADDR);
    wire wr_strobe = byte_done && !is_addr && !is_ptr;
    wire [7:0] wr_data = shift;
    wire tx_load = (state == KIC_ACK && scl_fall && rw) || (state == KIC_MACK && scl_fall);
    wire rd_strobe = tx_load;

    wire wr_clear = wr_strobe && (pointer == `KIC_CLEAR_ADDR);
    wire wr_mask = wr_strobe && (pointer == `KIC_MASK_ADDR);
    wire in_code = (pointer >= `KIC_CODE0_ADDR) && (pointer <= `KIC_CODE3_ADDR);
    wire [7:0] code_off = pointer - `KIC_CODE0_ADDR;
    wire [1:0] code_idx = code_off[1:0];
    wire [7:0] code_data = slot[code_idx];
    // Clear register is write-only and reads back as zero
    wire [7:0] rd_data = (pointer == `KIC_MASK_ADDR) ? {4'h0, keypad_interrupt_mask} :
                         in_code ? code_data : 8'h00; // [R1] [R17]

    wire scan_set = scan_done_in && scan_changed_in; // [R18]
    wire all_codes_read = (read_seen == 4'hF); // [R13]
    wire clr_scan = (wr_clear && wr_data[`KIC_SCAN_CLR_BIT]) || all_codes_read; // [R4] [R13]
    wire clr_event = wr_clear && wr_data[`KIC_EVT_CLR_BIT]; // [R3]
    wire set_key_lost = (scan_set && raw.scan_change) || (scan_done_in && too_many_keys_in); // [R19]

    // Set wins over a clear arriving in the same cycle, except event_pend, where the flush wins
    kic_raw_irq_t next_raw;
    assign next_raw.scan_change = scan_set || (raw.scan_change && !clr_scan); // [R18] [R4]
    assign next_raw.key_lost = set_key_lost || (raw.key_lost && !clr_scan); // [R19] [R4]
    // Event flag mirrors the buffer; a flush empties it, so the flag drops with it
    assign next_raw.event_pend = event_pending_in && !clr_event; // [R20] [R3]
    assign next_raw.event_lost = event_overflow_in || (raw.event_lost && !clr_event); // [R21] [R3]

    // Request uses the mask as it stood before a same-cycle mask write
    wire [3:0] next_unmasked = next_raw & ~keypad_interrupt_mask; // [R5] [R6] [R7] [R8] [R9]

    // Next key code for each slot; empty slots show the no-key code
    kic_key_code_t next_slot [0:3];
    genvar gi;
    generate
        for (gi = 0; gi < `KIC_KEY_SLOTS; gi = gi + 1)
        begin : g_slot
            wire more_key = (gi == `KIC_KEY_SLOTS - 1) ? too_many_keys_in : key_valid_in[(gi + 1) % 4]; // [R12]
            assign next_slot[gi].more = key_valid_in[gi] && more_key; // [R12] [R11]
            assign next_slot[gi].row = key_valid_in[gi] ? key_in[gi].row : `KIC_ROW_RESET; // [R15] [R14]
            assign next_slot[gi].col = key_valid_in[gi] ? key_in[gi].col : `KIC_COL_RESET; // [R16] [R14]
            always_ff @(posedge ref_clk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                    slot[gi] <= {1'b0, `KIC_ROW_RESET, `KIC_COL_RESET}; // [R15] [R16]
                else if (scan_set)
                    slot[gi] <= next_slot[gi]; // [R11]
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_q <= sda_s;
        end
    end

    // Register side effects
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            keypad_interrupt_mask <= `KIC_MASK_RESET; // [R8] [R9]
            special_key_scan_off_out <= 1'b0;
            event_buffer_clear_out <= 1'b0;
            raw <= '0;
            raw_irq_out <= '0;
            irq_out <= 1'b0;
            read_seen <= 4'h0;
        end
        else
        begin
            if (wr_mask)
                keypad_interrupt_mask <= wr_data[3:0]; // [R6] [R7] [R8] [R9]
            if (wr_clear)
                special_key_scan_off_out <= wr_data[`KIC_SF_OFF_BIT]; // [R2]
            event_buffer_clear_out <= clr_event; // [R3]
            raw <= next_raw;
            raw_irq_out <= next_raw;
            irq_out <= |next_unmasked; // [R22] [R5]
            if (scan_set || all_codes_read)
                read_seen <= 4'h0; // [R13]
            else if (rd_strobe && in_code)
                read_seen[code_idx] <= 1'b1; // [R13]
        end
    end

    // Serial slave: received bytes shift in on SCL rise, SDA changes on SCL fall
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= KIC_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            pointer <= 8'h00;
            is_addr <= 1'b0;
            is_ptr <= 1'b0;
            rw <= 1'b0;
            sda_oe_out <= 1'b0;
            sda_out <= 1'b0;
        end
        else if (bus_start)
        begin
            state <= KIC_RX;
            bit_cnt <= 4'h0;
            is_addr <= 1'b1;
            is_ptr <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else if (bus_stop)
        begin
            state <= KIC_IDLE;
            sda_oe_out <= 1'b0;
        end
        else
        begin
            unique case (state)
                KIC_IDLE:
                begin
                    sda_oe_out <= 1'b0;
                end
                KIC_RX:
                begin
                    if (scl_rise && bit_cnt != `KIC_BITS_PER_BYTE)
                    begin
                        shift <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        bit_cnt <= 4'h0;
                        if (is_addr && !addr_hit)
                            state <= KIC_IDLE;
                        else
                        begin
                            state <= KIC_ACK;
                            sda_oe_out <= 1'b1;
                            is_addr <= 1'b0;
                            is_ptr <= is_addr && !shift[0];
                            if (is_addr)
                                rw <= shift[0];
                            if (is_ptr)
                                pointer <= shift;
                            if (wr_strobe)
                                pointer <= pointer + 8'h01;
                        end
                    end
                end
                KIC_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rw)
                        begin
                            state <= KIC_TX;
                            shift <= rd_data;
                            sda_oe_out <= ~rd_data[7];
                            pointer <= pointer + 8'h01;
                        end
                        else
                        begin
                            state <= KIC_RX;
                            sda_oe_out <= 1'b0;
                        end
                    end
                end
                KIC_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt == 4'h7)
                        begin
                            bit_cnt <= 4'h0;
                            sda_oe_out <= 1'b0;
                            state <= KIC_MACK;
                        end
                        else
                        begin
                            bit_cnt <= bit_cnt + 4'h1;
                            shift <= {shift[6:0], 1'b0};
                            sda_oe_out <= ~shift[6];
                        end
                    end
                end
                KIC_MACK:
                begin
                    if (scl_rise && sda_s)
                        state <= KIC_IDLE;
                    else if (scl_fall)
                    begin
                        state <= KIC_TX;
                        shift <= rd_data;
                        sda_oe_out <= ~rd_data[7];
                        pointer <= pointer + 8'h01;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_irq_follows_mask: assert property ( // [R22]
        irq_out == |(raw & ~$past(keypad_interrupt_mask)))
        else $error("request output does not match unmasked raw flags");
    a_scan_clear: assert property (
        (wr_clear && wr_data[0] && !scan_set && !set_key_lost) |=> !raw.scan_change && !raw.key_lost) // [R4]
        else $error("scan change not cleared by clear bit 0");
    a_event_flush: assert property (
        (clr_event && !event_overflow_in) |=> event_buffer_clear_out && !raw.event_lost && !raw.event_pend) // [R3]
        else $error("event flush did not clear event flags");
    a_sf_off_bit: assert property (
        wr_clear |=> special_key_scan_off_out == $past(wr_data[7])) // [R2]
        else $error("special key scan control not taken from bit 7");
    a_masked_quiet: assert property (
        (keypad_interrupt_mask == 4'hF) [*2] |-> !irq_out) // [R5]
        else $error("request raised while every source is masked");
    a_scan_set: assert property (
        scan_set |=> raw.scan_change && (slot[0] == $past(next_slot[0]))) // [R18]
        else $error("scan change not recorded at end of scan");
    a_key_lost_set: assert property (
        (scan_done_in && too_many_keys_in) |=> raw.key_lost) // [R19]
        else $error("key lost not set on too many keys");
    a_lost_event: assert property (
        event_overflow_in |=> raw.event_lost [*1] ##1 (raw.event_lost || $past(clr_event))) // [R21]
        else $error("event lost flag not held after overflow");
    a_event_follow: assert property (
        (event_pending_in && !clr_event) |=> raw.event_pend) // [R20]
        else $error("event flag does not follow buffer");
    a_reads_clear: assert property (
        (all_codes_read && !scan_set) |=> !raw.scan_change && read_seen == 4'h0) // [R13]
        else $error("reading all codes did not clear scan change");
    a_more_flag: assert property (
        scan_set && key_valid_in[0] && key_valid_in[1] |=> slot[0].more) // [R12]
        else $error("more keys flag missing on first code");
    a_empty_code: assert property (
        scan_set && !key_valid_in[0] |=> slot[0] == 8'h7F) // [R14] [R15] [R16]
        else $error("first code not 0x7F with no key");

endmodule : kic_bank
`default_nettype wire

/* bench/kic_host.sv */
/* Two-wire bus master model standing in for the host processor.
   Assumes the bench pulls the data line high and calls these tasks. */
`timescale 1ns/1ns
`default_nettype none
module kic_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
        rd_data_out = 8'h00;
        rd_valid_out = 1'b0;
    end
    task automatic half(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : half
    // SCL high eight clocks and low ten, twice what the slave needs; data moves two clocks after SCL falls
    task automatic bit_io(input logic b, output logic r);
        half(2);
        sda_pull_out = ~b;
        half(8);
        scl_out = 1'b1;
        half(8);
        r = sda_in;
        scl_out = 1'b0;
    endtask : bit_io
    task automatic start();
        half(2);
        sda_pull_out = 1'b0;
        half(8);
        scl_out = 1'b1;
        half(8);
        sda_pull_out = 1'b1;
        half(8);
        scl_out = 1'b0;
    endtask : start
    task automatic stop();
        half(2);
        sda_pull_out = 1'b1;
        half(8);
        scl_out = 1'b1;
        half(8);
        sda_pull_out = 1'b0;
        half(8);
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put
    // Last byte of a burst is refused so the slave lets go of the line
    task automatic get(input logic last);
        logic r;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
        rd_data_out = d;
        rd_valid_out = 1'b1;
        half(1);
        rd_valid_out = 1'b0;
    endtask : get
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
        logic a;
        start();
        put({dev, 1'b0}, ack);
        put(ptr, a);
        put(d, a);
        stop();
    endtask : wr
    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input int n);
        logic a;
        start();
        put({dev, 1'b0}, a);
        put(ptr, a);
        start();
        put({dev, 1'b1}, a);
        for (int i = 0; i < n; i++)
            get(i == n - 1);
        stop();
    endtask : rd
endmodule : kic_host
`default_nettype wire

/* bench/kic_bank_bench.sv */
/* Self-checking bench for the keypad clear, mask and key code register bank.
   Assumes kic_host as bus master; the bench drives the scan side itself. */
`timescale 1ns/1ns
`default_nettype none
module kic_bank_bench;
    import kic_pkg::*;
    localparam logic [6:0] BUS = 7'h35;
    logic clk, rst_b, scan_done, scan_changed, too_many, ev_pend, ev_ovf;
    logic sda_oe, sda_o, ev_clr, sf_off, irq, scl, host_pull, rd_valid, a;
    logic [3:0] key_valid;
    logic [7:0] rd_data;
    logic [8:0] e;
    logic [31:0] w;
    logic [31:0] seed = 32'h0000_0008;
    logic [8:0] expq[$];
    kic_key_code_t [3:0] keys;
    kic_raw_irq_t raw;
    int n_fail = 0, checks = 0, cycles = 0, n_clr = 0, clr0 = 0;
    wire sda = ~(host_pull | (sda_oe & ~sda_o));
    kic_bank #(.BUS_ADDR(BUS)) uut (.ref_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .scan_done_in(scan_done), .scan_changed_in(scan_changed),
        .too_many_keys_in(too_many), .key_valid_in(key_valid), .key_in(keys), .event_pending_in(ev_pend),
        .event_overflow_in(ev_ovf), .event_buffer_clear_out(ev_clr), .special_key_scan_off_out(sf_off),
        .raw_irq_out(raw), .irq_out(irq));
    kic_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(host_pull),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic end_sim();
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        host.wr(BUS, ptr, d, a);
        cmp({7'h00, a}, 8'h01);
    endtask : wr
    // Bit 8 of a note marks a byte whose value is left open
    task automatic rdq(input logic [7:0] ptr, input logic [8:0] ex[]);
        foreach (ex[i])
            expq.push_back(ex[i]);
        host.rd(BUS, ptr, ex.size());
    endtask : rdq
    task automatic scan(input logic ch, input logic many);
        scan_changed = ch;
        too_many = many;
        scan_done = 1'b1;
        tick();
        scan_done = 1'b0;
        tick();
    endtask : scan
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            end_sim();
        end
        if (ev_clr)
            n_clr++;
        if (rd_valid)
        begin
            e = expq.pop_front();
            if (!e[8])
                cmp(rd_data, e[7:0]);
        end
    end
    initial
    begin
        {rst_b, scan_done, scan_changed, too_many, ev_pend, ev_ovf} = 6'h00;
        key_valid = 4'h0;
        keys = '0;
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (4) tick();
        cmp({4'h0, raw}, 8'h00);
        rdq(8'h08, '{9'h000, 9'h003, 9'h000, 9'h07F, 9'h07F});
        foreach (keys[i])
        begin
            w = xs();
            keys[i] = {w[7], w[6:4], w[3:0] % 4'hD};
        end
        key_valid = 4'h3;
        scan(1'b1, 1'b0);
        cmp({4'h0, raw}, 8'h01);
        cmp({7'h00, irq}, 8'h00);
        wr(8'h09, 8'h00);
        cmp({7'h00, irq}, 8'h01);
        rdq(8'h0B, '{{2'b01, keys[0].row, keys[0].col}, {2'b00, keys[1].row, keys[1].col}, 9'h07F, 9'h07F});
        cmp({4'h0, raw}, 8'h00);
        cmp({7'h00, irq}, 8'h00);
        scan(1'b1, 1'b0);
        scan(1'b1, 1'b0);
        cmp({4'h0, raw}, 8'h03);
        wr(8'h08, 8'h01);
        cmp({4'h0, raw}, 8'h00);
        scan(1'b1, 1'b1);
        cmp({4'h0, raw}, 8'h03);
        ev_pend = 1'b1;
        ev_ovf = 1'b1;
        tick();
        ev_ovf = 1'b0;
        tick();
        cmp({4'h0, raw}, 8'h0F);
        wr(8'h09, 8'h0E);
        cmp({7'h00, irq}, 8'h01);
        wr(8'h08, 8'h01);
        cmp({4'h0, raw}, 8'h0C);
        cmp({7'h00, irq}, 8'h00);
        wr(8'h09, 8'h0D);
        cmp({7'h00, irq}, 8'h00);
        scan(1'b1, 1'b1);
        cmp({7'h00, irq}, 8'h01);
        wr(8'h08, 8'h01);
        cmp({4'h0, raw}, 8'h0C);
        wr(8'h09, 8'h0B);
        cmp({7'h00, irq}, 8'h01);
        ev_pend = 1'b0;
        repeat (2) tick();
        cmp({4'h0, raw}, 8'h08);
        cmp({7'h00, irq}, 8'h00);
        wr(8'h09, 8'h07);
        cmp({7'h00, irq}, 8'h01);
        clr0 = n_clr;
        wr(8'h08, 8'h02);
        cmp(8'(n_clr - clr0), 8'h01);
        cmp({4'h0, raw}, 8'h00);
        cmp({7'h00, irq}, 8'h00);
        host.wr(BUS ^ 7'h01, 8'h09, 8'hFF, a);
        cmp({7'h00, a}, 8'h00);
        rdq(8'h09, '{9'h007});
        wr(8'h08, 8'h80);
        cmp({7'h00, sf_off}, 8'h01);
        wr(8'h08, 8'h00);
        cmp({7'h00, sf_off}, 8'h00);
        wr(8'h09, 8'h0F);
        rdq(8'h09, '{9'h00F});
        key_valid = 4'h0;
        scan(1'b1, 1'b0);
        cmp({7'h00, irq}, 8'h00);
        rdq(8'h0B, '{9'h07F});
        end_sim();
    end
endmodule : kic_bank_bench
`default_nettype wire
